// ---- common/dbss_map.vh ----
`ifndef DBSS_MAP_VH
`define DBSS_MAP_VH

// Word width of the x18 configuration and its write-select split
`define DBSS_WORD_W 18
`define DBSS_SEL_W 2
`define DBSS_SEL_SPAN 9
// Burst address width, array reduced for simulation
`define DBSS_ADDR_W 6
`define DBSS_DEPTH 128
// Read latency as the last count of true-clock rises, one below the 2 rises before the half cycle
`define DBSS_RD_KEDGES 2'h1
// Output stage codes
`define DBSS_OUT_IDLE 2'h0
`define DBSS_OUT_WORD0 2'h1
`define DBSS_OUT_WORD1 2'h2
// Write stage codes
`define DBSS_WR_IDLE 2'h0
`define DBSS_WR_WORD0 2'h1
`define DBSS_WR_WORD1 2'h2
// Array commit stage codes
`define DBSS_CM_IDLE 2'h0
`define DBSS_CM_FIRST 2'h1
`define DBSS_CM_SECOND 2'h2

`endif

// ---- logic/dbss_array.v ----
`timescale 1ns/100ps
`include "dbss_map.vh"

module dbss_array
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Burst commit
  input wire commit_i,
  input wire [`DBSS_ADDR_W-1:0] wr_addr_i,
  input wire [`DBSS_WORD_W-1:0] wr_word0_i,
  input wire [`DBSS_WORD_W-1:0] wr_word1_i,
  input wire [`DBSS_SEL_W-1:0] wr_sel0_n_i,
  input wire [`DBSS_SEL_W-1:0] wr_sel1_n_i,
  // Read port
  input wire [`DBSS_ADDR_W-1:0] rd_addr_i,
  output wire [`DBSS_WORD_W-1:0] rd_word0_o,
  output wire [`DBSS_WORD_W-1:0] rd_word1_o
);

  reg [`DBSS_WORD_W-1:0] mem [0:`DBSS_DEPTH-1];
  reg [1:0] stage_q;
  reg [`DBSS_ADDR_W-1:0] addr_q;
  reg [`DBSS_WORD_W-1:0] w1_q;
  reg [`DBSS_SEL_W-1:0] s1_q;
  wire [`DBSS_WORD_W-1:0] cur_word;
  wire [`DBSS_SEL_W-1:0] cur_sel;
  wire [`DBSS_ADDR_W:0] cur_idx;
  wire [`DBSS_WORD_W-1:0] old_word;
  wire [`DBSS_WORD_W-1:0] merged;

  assign rd_word0_o = mem[{rd_addr_i, 1'b0}];
  assign rd_word1_o = mem[{rd_addr_i, 1'b1}];

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      stage_q <= `DBSS_CM_IDLE;
      addr_q <= {`DBSS_ADDR_W{1'b0}};
      w1_q <= {`DBSS_WORD_W{1'b0}};
      s1_q <= {`DBSS_SEL_W{1'b1}};
    end
    else
    begin
      case (stage_q)
        `DBSS_CM_IDLE:
        begin
          if (commit_i)
          begin
            stage_q <= `DBSS_CM_FIRST;
            addr_q <= wr_addr_i;
            w1_q <= wr_word1_i;
            s1_q <= wr_sel1_n_i;
          end
        end
        `DBSS_CM_FIRST:
        begin
          stage_q <= `DBSS_CM_SECOND;
        end
        default:
        begin
          stage_q <= `DBSS_CM_IDLE;
        end
      endcase
    end
  end

  // Word 0 is held on the inputs by the caller until its next burst
  assign cur_word = (stage_q == `DBSS_CM_FIRST) ? wr_word0_i : w1_q;
  assign cur_sel = (stage_q == `DBSS_CM_FIRST) ? wr_sel0_n_i : s1_q;
  assign cur_idx = {addr_q, (stage_q == `DBSS_CM_SECOND)};
  assign old_word = mem[cur_idx];

  genvar g;
  generate
    for (g = 0; g < `DBSS_SEL_W; g = g + 1)
    begin : g_lane
      assign merged[g*`DBSS_SEL_SPAN +: `DBSS_SEL_SPAN] = cur_sel[g] ?
        old_word[g*`DBSS_SEL_SPAN +: `DBSS_SEL_SPAN] :
        cur_word[g*`DBSS_SEL_SPAN +: `DBSS_SEL_SPAN];
    end
  endgenerate

  always @(posedge clk_i)
  begin
    if (stage_q != `DBSS_CM_IDLE)
      mem[cur_idx] <= merged;
  end

endmodule // dbss_array

// ---- logic/dbss_port.v ----
`timescale 1ns/100ps
`include "dbss_map.vh"

// Operation
// - An address is taken only on a true-clock rise, never on the rise right after one taken.
// - Write words are registered on the next true-clock rise and the following complement rise.
// - Read word 0 leaves on a complement-clock rise and word 1 on the next true-clock rise.
// - Each address holds two consecutive words of the fixed word width moved as one burst.
// - The first read word appears two and a half input cycles after its address edge.
// - The echo clocks follow the input clocks and switch together with the read data.
// - The valid flag is high exactly while read data is on the data pins.
// - Apart from the echo clocks, only rising edges of the two input clocks cause any action.
// - All pin inputs are registered and all data outputs leave from registers.
// - After the second write word the array write runs on its own timing.
// - The data bus is driven only during read bursts and is released otherwise.

module dbss_port
(
  // Core clock and reset
  input wire CORE_CLK_I,
  input wire RST_I,
  // Input clock pair
  input wire K_I,
  input wire K_N_I,
  // Command and address
  input wire LOAD_STROBE_N_I,
  input wire RW_I,
  input wire [`DBSS_ADDR_W-1:0] ADDR_I,
  input wire [`DBSS_SEL_W-1:0] NIBBLE_WRITE_SELECT_N_I,
  // Shared data bus
  input wire [`DBSS_WORD_W-1:0] DQ_I,
  output wire [`DBSS_WORD_W-1:0] DQ_O,
  output wire DQ_OE_O,
  // Echo clocks and valid
  output wire ECHO_CLOCK_OUT_O,
  output wire ECHO_CLOCK_OUT_N_O,
  output wire READ_VALID_FLAG_O
);

  // Synchroniser and edge-history stages
  reg [2:0] k_q;
  reg [2:0] kn_q;
  reg [1:0] strobe_n_q;
  reg [1:0] rw_q;
  reg [`DBSS_ADDR_W-1:0] addr_s1_q;
  reg [`DBSS_ADDR_W-1:0] addr_s2_q;
  reg [`DBSS_SEL_W-1:0] sel_s1_q;
  reg [`DBSS_SEL_W-1:0] sel_s2_q;
  reg [`DBSS_WORD_W-1:0] dq_s1_q;
  reg [`DBSS_WORD_W-1:0] dq_s2_q;
  wire k_rise;
  wire kn_rise;
  wire start;

  always @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      k_q <= 3'h0;
      kn_q <= 3'h0;
      strobe_n_q <= 2'h3;
      rw_q <= 2'h3;
      addr_s1_q <= {`DBSS_ADDR_W{1'b0}};
      addr_s2_q <= {`DBSS_ADDR_W{1'b0}};
      sel_s1_q <= {`DBSS_SEL_W{1'b1}};
      sel_s2_q <= {`DBSS_SEL_W{1'b1}};
      dq_s1_q <= {`DBSS_WORD_W{1'b0}};
      dq_s2_q <= {`DBSS_WORD_W{1'b0}};
    end
    else
    begin
      k_q <= {k_q[1:0], K_I};
      kn_q <= {kn_q[1:0], K_N_I};
      strobe_n_q <= {strobe_n_q[0], LOAD_STROBE_N_I};
      rw_q <= {rw_q[0], RW_I};
      addr_s1_q <= ADDR_I;
      addr_s2_q <= addr_s1_q;
      sel_s1_q <= NIBBLE_WRITE_SELECT_N_I;
      sel_s2_q <= sel_s1_q;
      dq_s1_q <= DQ_I;
      dq_s2_q <= dq_s1_q;
    end
  end

  assign k_rise = k_q[1] & ~k_q[2];
  assign kn_rise = kn_q[1] & ~kn_q[2];

  // Address capture
  reg busy_q;
  reg [`DBSS_ADDR_W-1:0] wr_addr_q;
  reg [1:0] wr_stage_q;
  reg [`DBSS_WORD_W-1:0] w0_q;
  reg [`DBSS_WORD_W-1:0] w1_q;
  reg [`DBSS_SEL_W-1:0] s0_q;
  reg [`DBSS_SEL_W-1:0] s1_q;
  reg commit_q;
  reg rd_pend_q;
  reg [1:0] rd_cnt_q;
  reg [`DBSS_ADDR_W-1:0] rd_addr_q;
  wire [`DBSS_WORD_W-1:0] arr_w0;
  wire [`DBSS_WORD_W-1:0] arr_w1;

  assign start = k_rise & ~busy_q & ~strobe_n_q[1];

  always @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      busy_q <= 1'b0;
    else if (k_rise)
      busy_q <= start;
  end

  // write words on both clock rises
  always @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      wr_stage_q <= `DBSS_WR_IDLE;
      wr_addr_q <= {`DBSS_ADDR_W{1'b0}};
      w0_q <= {`DBSS_WORD_W{1'b0}};
      w1_q <= {`DBSS_WORD_W{1'b0}};
      s0_q <= {`DBSS_SEL_W{1'b1}};
      s1_q <= {`DBSS_SEL_W{1'b1}};
      commit_q <= 1'b0;
    end
    else
    begin
      commit_q <= 1'b0;
      case (wr_stage_q)
        `DBSS_WR_IDLE:
        begin
          if (start & ~rw_q[1])
          begin
            wr_stage_q <= `DBSS_WR_WORD0;
            wr_addr_q <= addr_s2_q;
          end
        end
        `DBSS_WR_WORD0:
        begin
          if (k_rise)
          begin
            w0_q <= dq_s2_q;
            s0_q <= sel_s2_q;
            wr_stage_q <= `DBSS_WR_WORD1;
          end
        end
        `DBSS_WR_WORD1:
        begin
          if (kn_rise)
          begin
            w1_q <= dq_s2_q;
            s1_q <= sel_s2_q;
            commit_q <= 1'b1;
            wr_stage_q <= `DBSS_WR_IDLE;
          end
        end
        default:
        begin
          wr_stage_q <= `DBSS_WR_IDLE;
        end
      endcase
    end
  end

  dbss_array u_array
  (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .commit_i(commit_q),
    .wr_addr_i(wr_addr_q),
    .wr_word0_i(w0_q),
    .wr_word1_i(w1_q),
    .wr_sel0_n_i(s0_q),
    .wr_sel1_n_i(s1_q),
    .rd_addr_i(rd_addr_q),
    .rd_word0_o(arr_w0),
    .rd_word1_o(arr_w1)
  );

  // Read launch stage
  reg arm_q;
  reg [1:0] out_q;
  reg [`DBSS_WORD_W-1:0] b0_q;
  reg [`DBSS_WORD_W-1:0] b1_q;
  reg [`DBSS_WORD_W-1:0] dq_q;
  reg oe_q;
  reg vld_q;
  reg echo_q;
  reg echo_n_q;

  always @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rd_pend_q <= 1'b0;
      rd_cnt_q <= 2'h0;
      rd_addr_q <= {`DBSS_ADDR_W{1'b0}};
      arm_q <= 1'b0;
      b0_q <= {`DBSS_WORD_W{1'b0}};
      b1_q <= {`DBSS_WORD_W{1'b0}};
    end
    else
    begin
      if (k_rise & rd_pend_q & (rd_cnt_q == `DBSS_RD_KEDGES))
      begin
        // Array is read late so a write just before is seen
        arm_q <= 1'b1;
        b0_q <= arr_w0;
        b1_q <= arr_w1;
      end
      else if (kn_rise & arm_q)
        arm_q <= 1'b0;
      if (start & rw_q[1])
      begin
        rd_pend_q <= 1'b1;
        rd_cnt_q <= 2'h0;
        rd_addr_q <= addr_s2_q;
      end
      else if (k_rise & rd_pend_q)
      begin
        rd_cnt_q <= rd_cnt_q + 2'h1;
        if (rd_cnt_q == `DBSS_RD_KEDGES)
          rd_pend_q <= 1'b0;
      end
    end
  end

  always @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      out_q <= `DBSS_OUT_IDLE;
      dq_q <= {`DBSS_WORD_W{1'b0}};
      oe_q <= 1'b0;
      vld_q <= 1'b0;
    end
    else
    begin
      case (out_q)
        `DBSS_OUT_IDLE:
        begin
          if (kn_rise & arm_q)
          begin
            dq_q <= b0_q;
            oe_q <= 1'b1;
            vld_q <= 1'b1;
            out_q <= `DBSS_OUT_WORD0;
          end
        end
        `DBSS_OUT_WORD0:
        begin
          if (k_rise)
          begin
            dq_q <= b1_q;
            out_q <= `DBSS_OUT_WORD1;
          end
        end
        `DBSS_OUT_WORD1:
        begin
          if (kn_rise)
          begin
            oe_q <= 1'b0;
            vld_q <= 1'b0;
            out_q <= `DBSS_OUT_IDLE;
          end
        end
        default:
        begin
          out_q <= `DBSS_OUT_IDLE;
        end
      endcase
    end
  end

  // echo clocks share the data edge
  always @(posedge CORE_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      echo_q <= 1'b0;
      echo_n_q <= 1'b0;
    end
    else
    begin
      echo_q <= k_q[1];
      echo_n_q <= kn_q[1];
    end
  end

  assign DQ_O = dq_q;
  assign DQ_OE_O = oe_q;
  assign READ_VALID_FLAG_O = vld_q;
  assign ECHO_CLOCK_OUT_O = echo_q;
  assign ECHO_CLOCK_OUT_N_O = echo_n_q;

endmodule // dbss_port

// ---- dv/dbss_port_monitor.sv ----
`timescale 1ns/100ps
`include "dbss_map.vh"
module dbss_port_monitor
(
  // Clock and reset
  input wire CORE_CLK_I,
  input wire RST_I,
  // Link inputs
  input wire K_I,
  input wire K_N_I,
  input wire LOAD_STROBE_N_I,
  input wire RW_I,
  // Device outputs
  input wire [`DBSS_WORD_W-1:0] DQ_O,
  input wire DQ_OE_O,
  input wire ECHO_CLOCK_OUT_O,
  input wire ECHO_CLOCK_OUT_N_O,
  input wire READ_VALID_FLAG_O
);
  wire strobe = !LOAD_STROBE_N_I;
  wire rd_cmd = strobe && RW_I;
  wire wr_cmd = strobe && !RW_I;
  wire vld = READ_VALID_FLAG_O;
  reg [2:0] up_q;
  // Echo history is stale for a few cycles after reset
  always @(posedge CORE_CLK_I or posedge RST_I)
    if (RST_I)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // Edge seen 3 cycles late; a strobe right after a taken edge is refused
  sequence rd_take;
    $rose(ECHO_CLOCK_OUT_O) && $past(rd_cmd, 3) && !$past(strobe, 11);
  endsequence
  sequence wr_take;
    $rose(ECHO_CLOCK_OUT_O) && $past(wr_cmd, 3) && !$past(strobe, 11);
  endsequence
  sequence burst;
    vld [*8] ##1 !vld;
  endsequence
  rd_latency_a: assert property (rd_take |-> ##20 $rose(vld))
    else $error("read data late or early");
  wr_no_data_a: assert property (wr_take |-> ##20 !$rose(vld))
    else $error("write gave read data");
  valid_len_a: assert property ($rose(vld) |-> burst)
    else $error("valid length wrong");
  oe_valid_a: assert property (DQ_OE_O == vld)
    else $error("bus drive differs from valid");
  valid_edge_a: assert property ($changed(vld) |-> $rose(ECHO_CLOCK_OUT_N_O))
    else $error("valid off echo edge");
  word_step_a: assert property (vld && $past(vld) && $changed(DQ_O) |-> $rose(ECHO_CLOCK_OUT_O))
    else $error("word changed off echo edge");
  echo_true_a: assert property (up_q == 3'h7 |-> ECHO_CLOCK_OUT_O == $past(K_I, 3))
    else $error("echo does not follow clock");
  echo_comp_a: assert property (up_q == 3'h7 |-> ECHO_CLOCK_OUT_N_O == $past(K_N_I, 3))
    else $error("echo pair does not follow clock");
  rd_seen_c: cover property (rd_take);
endmodule // dbss_port_monitor

bind dbss_port dbss_port_monitor mon
(
  .CORE_CLK_I, .RST_I, .K_I, .K_N_I, .LOAD_STROBE_N_I, .RW_I, .DQ_O, .DQ_OE_O,
  .ECHO_CLOCK_OUT_O, .ECHO_CLOCK_OUT_N_O, .READ_VALID_FLAG_O
);

// ---- dv/dbss_ctl_model.sv ----
`timescale 1ns/100ps
`include "dbss_map.vh"
module dbss_ctl_model
(
  // Clock pair
  output reg k_o = 1'b0,
  output wire k_n_o,
  // Command and write data
  output reg strobe_n_o = 1'b1,
  output reg rw_o = 1'b1,
  output reg [`DBSS_ADDR_W-1:0] addr_o = 6'h0,
  output reg [`DBSS_SEL_W-1:0] sel_n_o = 2'h3,
  output reg [`DBSS_WORD_W-1:0] dq_o = 18'h0,
  output reg dq_oe_o = 1'b0,
  // Read capture
  input wire [`DBSS_WORD_W-1:0] dq_i,
  output reg done_o = 1'b0,
  output reg [35:0] rd_o = 36'h0
);
  reg acc_q = 1'b0;
  reg last_rd_q = 1'b0;
  reg cap_q = 1'b0;
  reg [2:0] rq_q = 3'h0;
  assign k_n_o = ~k_o;
  // Free running, phase unrelated to the core clock
  initial
  begin
    #7;
    forever #160 k_o = ~k_o;
  end
  always @(k_o)
    if (k_o)
    begin
      acc_q <= strobe_n_o ? 1'b0 : !acc_q;
      rq_q <= {rq_q[1:0], !strobe_n_o && !acc_q && rw_o};
      cap_q <= rq_q[2];
      done_o <= 1'b0;
      if (rq_q[2])
        rd_o[35:18] <= dq_i;
    end
    else if (cap_q)
    begin
      rd_o[17:0] <= dq_i;
      done_o <= 1'b1;
    end
  task op(input rd, input [5:0] a, input [35:0] d, input [3:0] s, input hold);
  begin
    repeat (!rd && last_rd_q ? 3 : 1) @(negedge k_o);
    last_rd_q = rd;
    // Strobe low, select high for read
    strobe_n_o <= 1'b0;
    rw_o <= rd;
    addr_o <= a;
    // Last write word must still stand after the complement rise just passed
    #80;
    dq_oe_o <= 1'b0;
    @(posedge k_o);
    if (hold)
      @(posedge k_o);
    // Two words, the first changed on the fall of k_o and the second mid phase, so each stands across its rise
    @(negedge k_o);
    strobe_n_o <= 1'b1;
    addr_o <= ~a;
    dq_oe_o <= !rd;
    dq_o <= d[35:18];
    sel_n_o <= s[3:2];
    @(posedge k_o);
    #80;
    dq_o <= d[17:0];
    sel_n_o <= s[1:0];
  end
  endtask
endmodule // dbss_ctl_model

// ---- dv/tb_ddr_burst2_sync_sram_port.sv ----
`timescale 1ns/100ps
`include "dbss_map.vh"
module tb_ddr_burst2_sync_sram_port;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg fill = 1'b1;
  wire k, kn, strobe_n, rw, c_oe, oe, val, done;
  wire [`DBSS_ADDR_W-1:0] addr;
  wire [`DBSS_SEL_W-1:0] sel_n;
  wire [`DBSS_WORD_W-1:0] c_dq, dq_o, bus;
  wire [35:0] rd;
  reg [17:0] mem [0:127];
  reg [35:0] exq [$];
  reg [35:0] d;
  reg [3:0] s;
  integer err_count = 0;
  integer compares = 0;
  integer cyc = 0;
  integer i;
  // Released bus toggles rather than keeping the last value
  assign bus = oe ? dq_o : c_oe ? c_dq : {9{k, kn}};
  always #20 clk = ~clk;
  dbss_port dut
  (
    .CORE_CLK_I(clk), .RST_I(rst), .K_I(k), .K_N_I(kn),
    .LOAD_STROBE_N_I(strobe_n), .RW_I(rw), .ADDR_I(addr),
    .NIBBLE_WRITE_SELECT_N_I(sel_n), .DQ_I(bus), .DQ_O(dq_o), .DQ_OE_O(oe),
    .ECHO_CLOCK_OUT_O(), .ECHO_CLOCK_OUT_N_O(), .READ_VALID_FLAG_O(val)
  );
  dbss_ctl_model ctl
  (
    .k_o(k), .k_n_o(kn), .strobe_n_o(strobe_n), .rw_o(rw), .addr_o(addr),
    .sel_n_o(sel_n), .dq_o(c_dq), .dq_oe_o(c_oe), .dq_i(bus),
    .done_o(done), .rd_o(rd)
  );
  function [17:0] mrg(input [17:0] o, input [17:0] n, input [1:0] sn);
    mrg = {sn[1] ? o[17:9] : n[17:9], sn[0] ? o[8:0] : n[8:0]};
  endfunction
  task chkd(input [35:0] got, input [35:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task chkf(input [1:0] got, input [1:0] exp);
    chkd({34'h0, got}, {34'h0, exp});
  endtask
  task stop_test;
  begin
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task go(input r, input [5:0] a, input h);
  begin
    d = {18'($urandom), 18'($urandom)};
    s = fill ? 4'h0 : 4'($urandom);
    if (r)
      exq.push_back({mem[{a, 1'b0}], mem[{a, 1'b1}]});
    else
    begin
      mem[{a, 1'b0}] = mrg(mem[{a, 1'b0}], d[35:18], s[3:2]);
      mem[{a, 1'b1}] = mrg(mem[{a, 1'b1}], d[17:0], s[1:0]);
    end
    ctl.op(r, a, d, s, h);
  end
  endtask
  always @(posedge done)
    chkd(rd, exq.pop_front());
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      err_count = err_count + 1;
      stop_test;
    end
  end
  initial
  begin
    void'($urandom(32'hddbcc722));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chkd({18'h0, dq_o}, 36'h0);
    chkf({oe, val}, 2'h0);
    repeat (4) @(posedge clk);
    for (i = 0; i < 64; i = i + 1)
      go(1'b0, i[5:0], 1'b0);
    fill = 1'b0;
    go(1'b1, 6'h0, 1'b0);
    go(1'b1, 6'h3f, 1'b0);
    for (i = 0; i < 300; i = i + 1)
      go(1'($urandom), 6'($urandom), 1'b0);
    go(1'b1, 6'h15, 1'b1);
    repeat (80) @(posedge clk);
    chkd(36'(exq.size()), 36'h0);
    stop_test;
  end
endmodule // tb_ddr_burst2_sync_sram_port
